//--- text_insert_pkg.sv
// Shared constants, types and helpers of the teletext line inserter
package text_insert_pkg;
    // Clock rate and derived timing
    localparam real CLK_MHZ = 200.0;
    localparam real T_FIRST_PAL_US = 9.78;
    localparam real T_FIRST_NTSC_US = 10.5;
    localparam int HCNT_W = 12;
    localparam logic [HCNT_W-1:0] FIRST_PAL_CYC =
        HCNT_W'(int'($ceil(T_FIRST_PAL_US * CLK_MHZ)));
    localparam logic [HCNT_W-1:0] FIRST_NTSC_CYC =
        HCNT_W'(int'($ceil(T_FIRST_NTSC_US * CLK_MHZ)));

    // Text bit rates and phase increments of the rate divider
    localparam int NCO_W = 24;
    localparam real RATE_PAL_MBPS = 6.9375;
    localparam real RATE_NTSC_MBPS = 5.7272;
    localparam real NCO_SPAN = 16777216.0;
    localparam logic [NCO_W-1:0] NCO_INC_PAL =
        NCO_W'(int'(RATE_PAL_MBPS / CLK_MHZ * NCO_SPAN));
    localparam logic [NCO_W-1:0] NCO_INC_NTSC =
        NCO_W'(int'(RATE_NTSC_MBPS / CLK_MHZ * NCO_SPAN));

    // Window capacity per standard
    localparam int BIT_IDX_W = 9;
    localparam int BITS_MAX = 360;
    localparam logic [BIT_IDX_W-1:0] BITS_PAL = 9'h168;
    localparam logic [BIT_IDX_W-1:0] BITS_WST = 9'h128;
    localparam logic [BIT_IDX_W-1:0] BITS_NABTS = 9'h120;

    // Other widths
    localparam int LINE_W = 10;
    localparam int DELAY_W = 6;

    typedef enum logic [1:0] {
        STD_PAL = 2'h0,
        STD_WST = 2'h1,
        STD_NABTS = 2'h2
    } std_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_ACTIVE = 3'h2,
        ST_DONE = 3'h4
    } phase_t;

    function automatic logic [BIT_IDX_W-1:0] bits_for(input std_t s);
        if (s == STD_PAL) begin
            return BITS_PAL;
        end else if (s == STD_WST) begin
            return BITS_WST;
        end
        return BITS_NABTS;
    endfunction

    function automatic logic [HCNT_W-1:0] first_for(input std_t s);
        return (s == STD_PAL) ? FIRST_PAL_CYC : FIRST_NTSC_CYC;
    endfunction

    function automatic logic [NCO_W-1:0] inc_for(input std_t s);
        return (s == STD_PAL) ? NCO_INC_PAL : NCO_INC_NTSC;
    endfunction
endpackage

//--- bit_rate_nco.sv
// Phase accumulator that turns the clock into a text-bit-rate enable
`timescale 1ns/1ps
module bit_rate_nco (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic restart_in,
    input wire logic [text_insert_pkg::NCO_W-1:0] inc_in,
    output logic tick_out
);
    import text_insert_pkg::*;

    typedef struct packed {
        logic [NCO_W-1:0] acc;
        logic tick;
    } nco_t;

    nco_t s_r;
    nco_t s_nxt;
    logic [NCO_W:0] sum;

    // Carry out of the accumulator marks one bit period
    always_comb begin
        sum = {1'b0, s_r.acc} + {1'b0, inc_in};
        s_nxt.acc = sum[NCO_W-1:0];
        s_nxt.tick = sum[NCO_W];
        if (restart_in) begin
            s_nxt = '0; // Phase realigned so bit edges follow the start
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick_out = s_r.tick;
endmodule

//--- text_line_inserter.sv
// Teletext request, capture and insertion-window logic of the encoder
//
// Contract
// - First bit out 9.78/10.5 us after sync
// - Programmable request-to-data sampling delay
// - Programmable start of request pulse train
// - PAL window: 360 bits at 6.9375 Mbit/s
// - WST 296, NABTS 288 bits, 5.7272 Mbit/s
// - Window stays closed when insert disabled
// - Odd and even field line ranges
`timescale 1ns/1ps
module text_line_inserter #(
    parameter int DELAY_MAX = 64
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic hsync_lead_in,
    input wire logic field_odd_in,
    input wire logic [text_insert_pkg::LINE_W-1:0] line_number_in,
    input wire logic text_insert_enable_in,
    input wire text_insert_pkg::std_t standard_in,
    input wire logic [text_insert_pkg::HCNT_W-1:0] request_pulse_start_in,
    input wire logic [text_insert_pkg::DELAY_W-1:0] request_data_delay_in,
    input wire logic [text_insert_pkg::LINE_W-1:0] odd_field_first_line_in,
    input wire logic [text_insert_pkg::LINE_W-1:0] odd_field_last_line_in,
    input wire logic [text_insert_pkg::LINE_W-1:0] even_field_first_line_in,
    input wire logic [text_insert_pkg::LINE_W-1:0] even_field_last_line_in,
    input wire logic text_bit_in,
    output logic text_request_out,
    output logic window_open_out,
    output logic [1:0] text_level_out
);
    import text_insert_pkg::*;

    typedef struct packed {
        phase_t state;
        std_t std;
        logic line_on;
        logic [HCNT_W-1:0] hcnt;
        logic req_run;
        logic [BIT_IDX_W-1:0] rq_left;
        logic [BIT_IDX_W-1:0] ins_left;
        logic [BIT_IDX_W-1:0] wr_idx;
        logic [BIT_IDX_W-1:0] rd_idx;
        logic [DELAY_MAX-1:0] pipe;
        logic req;
        logic win;
        logic cur;
        logic [1:0] level;
        logic [BITS_MAX-1:0] store;
    } st_t;

    localparam st_t ST_RST = '{state: ST_IDLE, std: STD_PAL, default: '0};
    localparam logic [HCNT_W-1:0] HCNT_MAX = '1;

    st_t s_r;
    st_t s_nxt;
    logic req_tick;
    logic ins_tick;
    logic req_restart;
    logic ins_restart;
    logic in_range;
    logic sample_hit;

    // Request train and insertion each get their own bit clock
    bit_rate_nco u_req_nco (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .restart_in(req_restart),
        .inc_in(inc_for(s_r.std)),
        .tick_out(req_tick)
    );

    bit_rate_nco u_ins_nco (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .restart_in(ins_restart),
        .inc_in(inc_for(s_r.std)),
        .tick_out(ins_tick)
    );

    // Field-dependent line range check
    always_comb begin
        if (field_odd_in) begin
            in_range = (line_number_in >= odd_field_first_line_in) &&
                (line_number_in <= odd_field_last_line_in);
        end else begin
            in_range = (line_number_in >= even_field_first_line_in) &&
                (line_number_in <= even_field_last_line_in);
        end
    end

    // Tap of the request history chosen by the data delay setting
    assign sample_hit = s_r.pipe[request_data_delay_in];

    // Line sequencing, request generation, capture and insertion
    always_comb begin
        s_nxt = s_r;
        req_restart = 1'b0;
        ins_restart = 1'b0;
        s_nxt.req = 1'b0;
        s_nxt.pipe = {s_r.pipe[DELAY_MAX-2:0], s_r.req};
        // One captured bit per request; source keeps to one per pulse
        if (sample_hit && s_r.wr_idx < bits_for(s_r.std)) begin
            s_nxt.store[s_r.wr_idx] = text_bit_in;
            s_nxt.wr_idx = s_r.wr_idx + 9'h001;
        end
        if (s_r.hcnt != HCNT_MAX) begin
            s_nxt.hcnt = s_r.hcnt + 12'h001;
        end
        case (s_r.state)
            ST_ACTIVE: begin
                // Train starts at the programmed offset from sync
                if (!s_r.req_run && s_r.rq_left != '0 &&
                    s_r.hcnt == request_pulse_start_in) begin
                    s_nxt.req_run = 1'b1;
                    req_restart = 1'b1;
                    s_nxt.req = 1'b1;
                    s_nxt.rq_left = s_r.rq_left - 9'h001;
                end else if (s_r.req_run && req_tick) begin
                    if (s_r.rq_left == '0) begin
                        s_nxt.req_run = 1'b0;
                    end else begin
                        s_nxt.req = 1'b1;
                        s_nxt.rq_left = s_r.rq_left - 9'h001;
                    end
                end
                // Window opens at the fixed time after the sync edge
                if (!s_r.win && s_r.ins_left != '0 &&
                    s_r.hcnt == first_for(s_r.std)) begin
                    s_nxt.win = 1'b1;
                    ins_restart = 1'b1;
                    s_nxt.cur = s_r.store[0];
                    s_nxt.rd_idx = 9'h001;
                    s_nxt.ins_left = s_r.ins_left - 9'h001;
                end else if (s_r.win && ins_tick) begin
                    if (s_r.ins_left == '0) begin
                        s_nxt.win = 1'b0;
                        s_nxt.cur = 1'b0;
                        s_nxt.state = ST_DONE;
                    end else begin
                        s_nxt.cur = s_r.store[s_r.rd_idx];
                        s_nxt.rd_idx = s_r.rd_idx + 9'h001;
                        s_nxt.ins_left = s_r.ins_left - 9'h001;
                    end
                end
            end
            ST_DONE: begin
                s_nxt.req_run = 1'b0;
            end
            default: begin
                s_nxt.win = 1'b0;
            end
        endcase
        // Sync edge restarts line state, counters and request pipe, not the store or NCOs; it outranks work in flight
        if (hsync_lead_in) begin
            s_nxt.hcnt = '0;
            s_nxt.std = standard_in;
            s_nxt.line_on = text_insert_enable_in && in_range;
            s_nxt.state = s_nxt.line_on ? ST_ACTIVE : ST_IDLE;
            s_nxt.rq_left = bits_for(standard_in);
            s_nxt.ins_left = bits_for(standard_in);
            s_nxt.wr_idx = '0;
            s_nxt.rd_idx = '0;
            s_nxt.req_run = 1'b0;
            s_nxt.req = 1'b0;
            s_nxt.pipe = '0;
            s_nxt.win = 1'b0;
            s_nxt.cur = 1'b0;
        end
        // Midpoint step at each bit edge softens the inserted waveform
        s_nxt.level = s_nxt.win ?
            ({1'b0, s_nxt.cur} + {1'b0, s_r.cur}) : 2'h0;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign text_request_out = s_r.req;
    assign window_open_out = s_r.win;
    assign text_level_out = s_r.level;

    // Helper: requests issued since the last sync edge
    logic [BIT_IDX_W:0] req_cnt_r;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            req_cnt_r <= '0;
        end else if (hsync_lead_in) begin
            req_cnt_r <= '0;
        end else if (s_r.req) begin
            req_cnt_r <= req_cnt_r + 10'h001;
        end
    end

    // Checks on the request and insertion timing
    property p_req_in_active;
        @(posedge clk_in) disable iff (rst_in)
        text_request_out |-> $past(s_r.state) == ST_ACTIVE;
    endproperty
    a_req_in_active: assert property (p_req_in_active)
        else $error("request outside active line");

    property p_req_spacing;
        @(posedge clk_in) disable iff (rst_in)
        text_request_out |=> !text_request_out [*8];
    endproperty
    a_req_spacing: assert property (p_req_spacing)
        else $error("requests faster than bit rate");

    property p_closed_disabled;
        @(posedge clk_in) disable iff (rst_in)
        (hsync_lead_in && !text_insert_enable_in) |=>
            (!window_open_out && !text_request_out) until hsync_lead_in;
    endproperty
    a_closed_disabled: assert property (p_closed_disabled)
        else $error("window opened while disabled");

    property p_first_bit_time;
        @(posedge clk_in) disable iff (rst_in)
        $rose(window_open_out) |->
            s_r.hcnt == first_for(s_r.std) + 12'h001;
    endproperty
    a_first_bit_time: assert property (p_first_bit_time)
        else $error("first bit at wrong time");

    property p_req_start;
        @(posedge clk_in) disable iff (rst_in)
        $rose(s_r.req_run) |->
            s_r.hcnt == $past(request_pulse_start_in) + 12'h001;
    endproperty
    a_req_start: assert property (p_req_start)
        else $error("request train at wrong offset");

    property p_sample_delay;
        @(posedge clk_in) disable iff (rst_in)
        ($changed(s_r.wr_idx) && !$past(hsync_lead_in)) |->
            $past(sample_hit);
    endproperty
    a_sample_delay: assert property (p_sample_delay)
        else $error("bit captured without delayed request");

    property p_req_count;
        @(posedge clk_in) disable iff (rst_in)
        req_cnt_r <= {1'b0, bits_for(s_r.std)};
    endproperty
    a_req_count: assert property (p_req_count)
        else $error("too many requests on a line");

    property p_line_range;
        @(posedge clk_in) disable iff (rst_in)
        (hsync_lead_in && text_insert_enable_in) |=>
            s_r.line_on == $past(in_range);
    endproperty
    a_line_range: assert property (p_line_range)
        else $error("line range decision wrong");

    property p_level_gated;
        @(posedge clk_in) disable iff (rst_in)
        !window_open_out |-> text_level_out == 2'h0;
    endproperty
    a_level_gated: assert property (p_level_gated)
        else $error("level driven outside window");

    c_window: cover property (@(posedge clk_in) disable iff (rst_in)
        $rose(window_open_out));
    c_request: cover property (@(posedge clk_in) disable iff (rst_in)
        text_request_out ##1 !text_request_out);
    c_done: cover property (@(posedge clk_in) disable iff (rst_in)
        s_r.state == ST_DONE);
endmodule

//--- text_source_model.sv
// Behavioural model of the external teletext bit source
`timescale 1ns/1ps
module text_source_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic new_line_in,
    input wire logic request_in,
    input wire logic [5:0] delay_in,
    output logic text_bit_out
);
    // Fixed bit pattern, bit 0 is a one so a captured first bit is visible
    localparam logic [31:0] PATTERN = 32'hB38F0E6D;
    logic [63:0] hist_r;
    logic valid;
    int unsigned count_r;

    // Request is registered, so the inserter samples it delay_in+1 cycles on
    assign valid = hist_r[delay_in];
    // Off the sampling cycle the line shows the wrong value on purpose
    assign text_bit_out = valid ? PATTERN[count_r % 32]
                                : ~PATTERN[count_r % 32];

    // One new bit for every request, restarted at each line
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hist_r <= '0;
            count_r <= 0;
        end else begin
            hist_r <= {hist_r[62:0], request_in};
            if (new_line_in) begin
                count_r <= 0;
            end else if (valid) begin
                count_r <= count_r + 1;
            end
        end
    end
endmodule

//--- text_line_inserter_bench.sv
// Self-checking bench of the teletext line inserter
`timescale 1ns/1ps
module text_line_inserter_bench;
    import text_insert_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic hsync = 1'b0;
    logic field_odd = 1'b0;
    logic [9:0] line_num = 10'h000;
    logic ins_en = 1'b0;
    std_t std_sel = STD_PAL;
    logic [11:0] req_start = 12'h000;
    logic [5:0] req_delay = 6'h00;
    logic text_bit;
    logic text_req;
    logic win_open;
    logic [1:0] level;
    int err_count = 0;
    int n_checks = 0;

    always #2.5 clk_in = ~clk_in;

    text_line_inserter dut (
        .clk_in(clk_in), .rst_in(rst_in), .hsync_lead_in(hsync),
        .field_odd_in(field_odd), .line_number_in(line_num),
        .text_insert_enable_in(ins_en), .standard_in(std_sel),
        .request_pulse_start_in(req_start),
        .request_data_delay_in(req_delay),
        .odd_field_first_line_in(10'h00A), .odd_field_last_line_in(10'h014),
        .even_field_first_line_in(10'h12C),
        .even_field_last_line_in(10'h136),
        .text_bit_in(text_bit), .text_request_out(text_req),
        .window_open_out(win_open), .text_level_out(level)
    );

    // Source answers each request after the programmed delay
    text_source_model src (
        .clk_in(clk_in), .rst_in(rst_in), .new_line_in(hsync),
        .request_in(text_req), .delay_in(req_delay),
        .text_bit_out(text_bit)
    );

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
            err_count++;
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One line: pulse sync, then watch requests and window for 13000 cycles
    task automatic run_line(input std_t s, input logic odd_f,
                            input logic [9:0] ln, input logic e,
                            input logic [11:0] st, input logic [5:0] d,
                            output int nreq, output int first_req,
                            output int first_win, output logic [1:0] lvl0,
                            output logic win_end);
        nreq = 0;
        first_req = -1;
        first_win = -1;
        lvl0 = 2'h3;
        @(negedge clk_in);
        std_sel = s;
        field_odd = odd_f;
        line_num = ln;
        ins_en = e;
        req_start = st;
        req_delay = d;
        hsync = 1'b1;
        @(negedge clk_in);
        hsync = 1'b0;
        // Count 0 is the first cycle after the edge that took the sync pulse
        for (int c = 0; c < 13000; c++) begin
            if (text_req === 1'b1) begin
                if (nreq == 0) begin
                    first_req = c;
                end
                nreq++;
            end
            if (win_open === 1'b1 && first_win < 0) begin
                first_win = c;
                lvl0 = level;
            end
            @(negedge clk_in);
        end
        win_end = win_open;
    endtask

    // Enabled line: count, start, window position and first bit
    task automatic line_ok(input string name, input std_t s,
                           input logic odd_f, input logic [9:0] ln,
                           input logic [11:0] st, input logic [5:0] d,
                           input int bits, input int win_at);
        int nreq;
        int fr;
        int fw;
        logic [1:0] l0;
        logic we;
        run_line(s, odd_f, ln, 1'b1, st, d, nreq, fr, fw, l0, we);
        check("request count", 16'(nreq), 16'(bits));
        check("first request", 16'(fr), 16'(st) + 16'h0001);
        check("window open", 16'(fw), 16'(win_at));
        check("first level", {14'h0000, l0}, 16'h0001);
        check("window end", {15'h0000, we}, 16'h0000);
        $display("test %s done", name);
    endtask

    // Line that must stay silent
    task automatic line_quiet(input string name, input logic odd_f,
                              input logic [9:0] ln, input logic e);
        int nreq;
        int fr;
        int fw;
        logic [1:0] l0;
        logic we;
        run_line(STD_PAL, odd_f, ln, e, 12'h064, 6'h03, nreq, fr, fw, l0, we);
        check("quiet requests", 16'(nreq), 16'h0000);
        check("quiet window", 16'(fw), 16'hFFFF);
        $display("test %s done", name);
    endtask

    // Hang guard well beyond the planned run length
    initial begin
        #480000;
        err_count++;
        results();
    end

    initial begin
        repeat (4) @(negedge clk_in);
        rst_in = 1'b0;
        @(negedge clk_in);
        check("reset request", {15'h0000, text_req}, 16'h0000);
        check("reset window", {15'h0000, win_open}, 16'h0000);
        $display("test reset done");
        line_ok("pal odd", STD_PAL, 1'b1, 10'h00F, 12'h064, 6'h03, 360,
                int'(FIRST_PAL_CYC) + 1);
        line_ok("wst even", STD_WST, 1'b0, 10'h136, 12'h000, 6'h00, 296,
                int'(FIRST_NTSC_CYC) + 1);
        line_ok("nabts odd", STD_NABTS, 1'b1, 10'h00A, 12'h1F4, 6'h3F, 288,
                int'(FIRST_NTSC_CYC) + 1);
        line_quiet("disabled", 1'b1, 10'h00F, 1'b0);
        line_quiet("odd past end", 1'b1, 10'h015, 1'b1);
        line_quiet("even before start", 1'b0, 10'h12B, 1'b1);
        results();
    end
endmodule
